// ---- logic/supwd_defines.svh ----
// timing constants of the supervisor watchdog and reset timer
`ifndef SUPWD_DEFINES_SVH
`define SUPWD_DEFINES_SVH
`define SUPWD_CLK_HZ 100000000
`define SUPWD_RST_MS 250
`define SUPWD_WD250_MS 250
`define SUPWD_WD650_MS 650
`define SUPWD_WD1500_MS 1500
`define SUPWD_WC_MS 5
`define SUPWD_CYC_PER_MS (`SUPWD_CLK_HZ / 1000)
`define SUPWD_SEL_OFF 2'b11
`define SUPWD_SEL_250 2'b10
`define SUPWD_SEL_650 2'b01
`endif

// ---- logic/supwd_pkg.sv ----
// types of the supervisor watchdog
`default_nettype none
package supwd_pkg;
  typedef enum logic [1:0] {SUPWD_ST_RESET, SUPWD_ST_RUN} supwd_state_e;
endpackage : supwd_pkg
`default_nettype wire

// ---- logic/supwd_top.sv ----
// reset, watchdog and write-cycle timing of the supply supervisor
`include "supwd_defines.svh"
`default_nettype none
module supwd_top #(
  parameter int unsigned RST_CYC = `SUPWD_RST_MS * `SUPWD_CYC_PER_MS,
  parameter int unsigned WD250_CYC = `SUPWD_WD250_MS * `SUPWD_CYC_PER_MS,
  parameter int unsigned WD650_CYC = `SUPWD_WD650_MS * `SUPWD_CYC_PER_MS,
  parameter int unsigned WD1500_CYC = `SUPWD_WD1500_MS * `SUPWD_CYC_PER_MS,
  parameter int unsigned WC_CYC = `SUPWD_WC_MS * `SUPWD_CYC_PER_MS
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic i_watchdog_period_sel_hi,
  input wire logic i_watchdog_period_sel_lo,
  input wire logic i_wd_restart,
  input wire logic i_low_supply,
  input wire logic i_write_stop,
  input wire logic i_wel_set,
  input wire logic i_wel_clear,
  output logic o_reset,
  output logic o_bus_enable,
  output logic o_bus_abort,
  output logic o_write_busy,
  output logic o_write_enable_latch,
  output logic o_standby
);
  logic [1:0] restart_sync_reg;
  logic [1:0] low_sync_reg;
  logic restart_prev_reg;
  logic [1:0] hi_lo_sync_reg;
  logic [1:0] lo_sync_reg;
  logic [31:0] rst_cnt_reg;
  logic [31:0] wd_cnt_reg;
  logic [31:0] wc_cnt_reg;
  logic [31:0] wd_limit;
  logic [1:0] sel;
  logic restart_edge;
  logic wd_expire;
  supwd_pkg::supwd_state_e state_reg;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      restart_sync_reg <= 2'h0;
      low_sync_reg <= 2'h0;
      hi_lo_sync_reg <= 2'h3;
      lo_sync_reg <= 2'h3;
      restart_prev_reg <= 1'b0;
    end else begin
      restart_sync_reg <= {restart_sync_reg[0], i_wd_restart};
      low_sync_reg <= {low_sync_reg[0], i_low_supply};
      hi_lo_sync_reg <= {hi_lo_sync_reg[0], i_watchdog_period_sel_hi};
      lo_sync_reg <= {lo_sync_reg[0], i_watchdog_period_sel_lo};
      restart_prev_reg <= restart_sync_reg[1];
    end
  end

  assign sel = {hi_lo_sync_reg[1], lo_sync_reg[1]};
  assign restart_edge = restart_sync_reg[1] & ~restart_prev_reg;

  always_comb begin
    if (sel == `SUPWD_SEL_250) begin
      wd_limit = WD250_CYC;
    end else if (sel == `SUPWD_SEL_650) begin
      wd_limit = WD650_CYC;
    end else begin
      wd_limit = WD1500_CYC;
    end
  end

  // the off code keeps the counter cleared so a later enable starts a full period
  assign wd_expire = (sel != `SUPWD_SEL_OFF) && (wd_cnt_reg >= wd_limit - 32'h0000_0001);

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_reg <= supwd_pkg::SUPWD_ST_RESET;
      rst_cnt_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        supwd_pkg::SUPWD_ST_RESET: begin
          // all inputs are ignored until the timeout runs out
          if (rst_cnt_reg >= RST_CYC - 32'h0000_0001 && !low_sync_reg[1]) begin
            state_reg <= supwd_pkg::SUPWD_ST_RUN;
            rst_cnt_reg <= 32'h0000_0000;
          end else if (rst_cnt_reg < RST_CYC - 32'h0000_0001) begin
            rst_cnt_reg <= rst_cnt_reg + 32'h0000_0001;
          end
        end
        supwd_pkg::SUPWD_ST_RUN: begin
          if (low_sync_reg[1] || wd_expire) begin
            state_reg <= supwd_pkg::SUPWD_ST_RESET;
          end
        end
        default: state_reg <= supwd_pkg::SUPWD_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST || state_reg != supwd_pkg::SUPWD_ST_RUN || sel == `SUPWD_SEL_OFF) begin
      wd_cnt_reg <= 32'h0000_0000;
    end else if (restart_edge || wd_expire) begin
      wd_cnt_reg <= 32'h0000_0000;
    end else begin
      wd_cnt_reg <= wd_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      wc_cnt_reg <= 32'h0000_0000;
    end else if (wc_cnt_reg != 32'h0000_0000) begin
      wc_cnt_reg <= wc_cnt_reg - 32'h0000_0001;
    end else if (i_write_stop && o_write_enable_latch && state_reg == supwd_pkg::SUPWD_ST_RUN) begin
      wc_cnt_reg <= WC_CYC;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      o_write_enable_latch <= 1'b0;
    end else if (state_reg != supwd_pkg::SUPWD_ST_RUN) begin
      o_write_enable_latch <= o_write_enable_latch;
    end else if (i_wel_set) begin
      o_write_enable_latch <= 1'b1;
    end else if (i_wel_clear) begin
      o_write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      o_reset <= 1'b1;
      o_bus_abort <= 1'b0;
    end else begin
      o_reset <= (state_reg != supwd_pkg::SUPWD_ST_RUN);
      o_bus_abort <= (state_reg == supwd_pkg::SUPWD_ST_RUN) && (low_sync_reg[1] || wd_expire);
    end
  end

  assign o_bus_enable = ~o_reset;
  assign o_write_busy = (wc_cnt_reg != 32'h0000_0000);
  assign o_standby = ~o_write_busy;

  a_wd_off_quiet: assert property (@(posedge I_CLK) disable iff (I_RST)
    (sel == `SUPWD_SEL_OFF) |-> !wd_expire) else $error("watchdog expired while off");
  a_wd_cnt_bound: assert property (@(posedge I_CLK) disable iff (I_RST)
    wd_cnt_reg < wd_limit || sel == `SUPWD_SEL_OFF || $changed(sel))
    else $error("watchdog count over limit");
  sequence s_trip;
    state_reg == supwd_pkg::SUPWD_ST_RUN && (low_sync_reg[1] || wd_expire);
  endsequence
  a_reset_follow: assert property (@(posedge I_CLK) disable iff (I_RST)
    s_trip |=> ##1 o_reset) else $error("reset not asserted after trip");
  a_reset_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
    $rose(o_reset) |-> o_reset[*8]) else $error("reset released early");
  a_pu_reset: assert property (@(posedge I_CLK)
    $fell(I_RST) |-> o_reset) else $error("no power-up reset");
  a_wc_len: assert property (@(posedge I_CLK) disable iff (I_RST)
    $rose(o_write_busy) |-> wc_cnt_reg == WC_CYC) else $error("write time wrong");
  a_bus_block: assert property (@(posedge I_CLK) disable iff (I_RST)
    o_reset |-> !o_bus_enable) else $error("bus open during reset");
  a_wel_pu: assert property (@(posedge I_CLK)
    $fell(I_RST) |-> !o_write_enable_latch && o_standby) else $error("bad power-up state");

  // cycles that reset has stood; a short repetition cannot span the full timeout
  logic [31:0] rst_len_reg;

  always_ff @(posedge I_CLK) begin
    if (I_RST || !o_reset) begin
      rst_len_reg <= 32'h0000_0000;
    end else if (rst_len_reg < RST_CYC) begin
      rst_len_reg <= rst_len_reg + 32'h0000_0001;
    end
  end

  sequence s_kick;
    state_reg == supwd_pkg::SUPWD_ST_RUN && restart_edge && !wd_expire;
  endsequence
  sequence s_write_go;
    state_reg == supwd_pkg::SUPWD_ST_RUN && i_write_stop && o_write_enable_latch && !o_write_busy;
  endsequence

  a_reset_len: assert property (@(posedge I_CLK) disable iff (I_RST)
    $fell(o_reset) |-> rst_len_reg >= RST_CYC)
    else $error("reset shorter than timeout");

  a_abort_pulse: assert property (@(posedge I_CLK) disable iff (I_RST)
    o_bus_abort |=> !o_bus_abort && o_reset)
    else $error("abort not a single pulse before reset");

  a_kick_clear: assert property (@(posedge I_CLK) disable iff (I_RST)
    s_kick |=> wd_cnt_reg == 32'h0000_0000)
    else $error("restart did not clear watchdog");

  a_off_clear: assert property (@(posedge I_CLK) disable iff (I_RST)
    (sel == `SUPWD_SEL_OFF) |=> wd_cnt_reg == 32'h0000_0000)
    else $error("watchdog counting while off");

  a_trip_low: assert property (@(posedge I_CLK) disable iff (I_RST)
    (state_reg == supwd_pkg::SUPWD_ST_RUN && low_sync_reg[1])
    |=> state_reg == supwd_pkg::SUPWD_ST_RESET)
    else $error("low supply did not trip reset");

  a_wel_frozen: assert property (@(posedge I_CLK) disable iff (I_RST)
    (state_reg != supwd_pkg::SUPWD_ST_RUN) |=> $stable(o_write_enable_latch))
    else $error("latch changed during reset");

  a_stop_refused: assert property (@(posedge I_CLK) disable iff (I_RST)
    (state_reg != supwd_pkg::SUPWD_ST_RUN && !o_write_busy) |=> !o_write_busy)
    else $error("write started during reset");

  a_write_start: assert property (@(posedge I_CLK) disable iff (I_RST)
    s_write_go |=> o_write_busy)
    else $error("valid stop did not start write");

  a_write_end: assert property (@(posedge I_CLK) disable iff (I_RST)
    (wc_cnt_reg == 32'h0000_0001) |=> !o_write_busy)
    else $error("write cycle overran");

  a_standby_busy: assert property (@(posedge I_CLK) disable iff (I_RST)
    o_write_busy |-> !o_standby)
    else $error("standby during write");

  a_wel_reset: assert property (@(posedge I_CLK)
    I_RST |=> !o_write_enable_latch && o_reset)
    else $error("reset state wrong");
endmodule : supwd_top
`default_nettype wire

// ---- tb/supwd_cpu_model.sv ----
// model of the supervised processor that kicks the watchdog
`default_nettype none
module supwd_cpu_model (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_reset,
  output logic o_kick
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_reg = 0;
  initial o_kick = 1'b0;
  // kicks every 16 cycles, well inside the shortest period; a held reset stops it
  always @(posedge i_clk) begin
    cnt_reg <= (cnt_reg == 15) ? 0 : cnt_reg + 1;
    o_kick <= i_en && !i_reset && (cnt_reg < 4);
  end
endmodule : supwd_cpu_model
`default_nettype wire

// ---- tb/supwd_top_tb_top.sv ----
// self-checking bench of the supervisor reset and watchdog timing
`default_nettype none
module supwd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, hi = 1, lo = 1, kick, low = 0, stop = 0, ws = 0, wc = 0, en = 0;
  logic ro, be, ab, busy, write_enable_latch, sb, w;
  int mismatches = 0, tests_run = 0, n, aborts = 0;
  logic [1:0] sel [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  int per [4] = '{130, 50, 80, 120};
  always #5 clk = ~clk;
  // every trip from run must give exactly one abort pulse
  always @(posedge clk) if (ab === 1'b1) aborts <= aborts + 1;
  supwd_top #(.RST_CYC(20), .WD250_CYC(50), .WD650_CYC(80), .WD1500_CYC(120), .WC_CYC(10))
    dut_u (.I_CLK(clk), .I_RST(rst), .i_watchdog_period_sel_hi(hi),
    .i_watchdog_period_sel_lo(lo), .i_wd_restart(kick), .i_low_supply(low),
    .i_write_stop(stop), .i_wel_set(ws), .i_wel_clear(wc), .o_reset(ro),
    .o_bus_enable(be), .o_bus_abort(ab), .o_write_busy(busy), .o_write_enable_latch(write_enable_latch),
    .o_standby(sb));
  supwd_cpu_model cpu_u (.i_clk(clk), .i_en(en), .i_reset(ro), .o_kick(kick));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk
  // counts cycles until reset shows v; f marks a bound that must not run out
  task automatic wt(input logic v, input int b, input bit f);
    n = 0;
    while (ro !== v && n < b) begin
      @(negedge clk);
      n++;
    end
    if (f && ro !== v) begin
      mismatches++;
      report_and_stop();
    end
  endtask : wt
  task automatic pulse(input bit s);
    @(posedge clk) if (s) stop <= 1; else wc <= 1;
    @(posedge clk) {stop, wc} <= 2'h0;
  endtask : pulse
  initial begin
    repeat (12) @(posedge clk);
    chk({ro, write_enable_latch, sb, be}, 4'h a);
    rst <= 0;
    @(posedge clk);
    wt(0, 40, 1);
    chk(n >= 20, 1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {hi, lo} <= sel[i];
      wt(1, 130, i > 0);
      chk(n >= per[i] && n <= per[i] + 8, 1);
      if (i > 0) begin
        chk(be, 0);
        wt(0, 40, 1);
        chk(n >= 20, 1);
      end
    end
    @(posedge clk) {hi, lo, en} <= 3'h5;
    wt(1, 300, 0);
    chk(n, 300);
    @(posedge clk) {en, ws} <= 2'h1;
    @(posedge clk) ws <= 0;
    pulse(1);
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < 20) @(negedge clk) n++;
    chk(n, 10);
    chk(sb, 1);
    @(posedge clk) low <= 1;
    wt(1, 10, 1);
    w = write_enable_latch;
    chk(be, 0);
    pulse(1);
    pulse(0);
    chk({busy, write_enable_latch}, {1'b0, w});
    @(posedge clk) low <= 0;
    wt(0, 40, 1);
    // four edges of the hold already passed before low supply was lifted
    chk(n + 4 >= 20, 1);
    chk(aborts, 4);
    report_and_stop();
  end
endmodule : supwd_top_tb_top
`default_nettype wire
